// *** background_debug_command_unit_tb_top.sv ***
// Self-checking bench for the debug command unit with a core model.
// Assumes the checker binds itself to the unit.
`timescale 1ns/1ps
module background_debug_command_unit_tb_top;
   logic mclk = 1'b0, reset = 1'b1, cmd_valid = 1'b0, bgnd_mode = 1'b1;
   logic cmd_ready, resp_valid, reg_rd, reg_wr, reg_sys, reg_ack, pg;
   logic mem_valid, mem_ack, pipe_flush, exit_bgnd, patch_go, periph_reset;
   logic [3:0] reg_idx, lat = 4'h0;
   logic [31:0] resp_data, reg_wdata, reg_rdata, mem_rdata;
   logic [31:0] pc_value = 32'h0000_4000, sp_value = 32'h0000_8000;
   logic [2:0] ssel = 3'h5, dsel = 3'h2;
   bdm_pkg::bdm_req_s cmd = '0;
   bdm_pkg::mem_req_s mem_req, lm;
   bdm_pkg::mem_size_e sz = bdm_pkg::size_long;
   int failures = 0, checks = 0, cyc = 0, fl_t = 0, ex_t = 0, rst_cnt = 0;
   bdm_cmd_unit bdm_cmd_unit_inst (.mclk, .reset, .cmd_valid, .cmd,
      .cmd_ready, .resp_valid, .resp_data, .bgnd_mode, .reg_rd, .reg_wr,
      .reg_sys, .reg_idx, .reg_wdata, .reg_ack, .reg_rdata, .pc_value,
      .sp_value, .source_space_select(ssel), .destination_space_select(dsel),
      .mem_valid, .mem_req, .mem_ack, .mem_rdata, .pipe_flush, .exit_bgnd,
      .patch_go, .periph_reset);
   core_model core_model_inst (.mclk, .reset, .lat, .reg_rd, .reg_wr,
      .reg_sys, .reg_idx, .reg_wdata, .reg_ack, .reg_rdata, .mem_valid,
      .mem_req, .mem_ack, .mem_rdata);
   // 40 MHz clock
   initial begin
      forever #12.5 mclk = ~mclk;
   end
   // Pulse times and finished memory requests, seen at the falling edge
   always @(negedge mclk) begin
      cyc <= cyc + 1;
      if (pipe_flush === 1'b1) fl_t <= cyc;
      if (exit_bgnd === 1'b1) ex_t <= cyc;
      if (patch_go === 1'b1) pg <= 1'b1;
      if (periph_reset === 1'b1) rst_cnt <= rst_cnt + 1;
      if (mem_valid === 1'b1 && mem_ack === 1'b1) lm <= mem_req;
   end
   task automatic chk(logic [31:0] got, logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic results;
      if (failures == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Offers one command, holds it until taken, waits for the answer
   task automatic send(bdm_pkg::bdm_cmd_e op, logic [3:0] sel,
         logic [31:0] a, logic [31:0] d);
      int n;
      @(negedge mclk);
      cmd = '{op, sel, sz, a, d};
      cmd_valid = 1'b1;
      while (cmd_ready !== 1'b1) @(negedge mclk);
      @(negedge mclk);
      cmd_valid = 1'b0;
      // No-op and reset answer in the cycle right after the take
      n = 0;
      while (resp_valid !== 1'b1 && n < 600) begin
         @(negedge mclk);
         n++;
      end
      chk({31'h0, resp_valid}, 32'h0000_0001);
   endtask
   // Register writes, a no-op, a refused write, then read-backs
   task automatic t_regs;
      int n;
      send(bdm_pkg::write_data_reg_cmd, 4'h3, '0, 32'h1111_2222);
      send(bdm_pkg::write_addr_reg_cmd, 4'h3, '0, 32'h3333_4444);
      send(bdm_pkg::write_sys_reg_cmd, 4'h2, '0, 32'h5555_6666);
      send(bdm_pkg::no_op_cmd, 4'h3, '0, 32'h7777_8888);
      n = 0;
      @(negedge mclk);
      bgnd_mode = 1'b0;
      cmd = '{bdm_pkg::write_data_reg_cmd, 4'h3, sz, '0, 32'hdead_beef};
      cmd_valid = 1'b1;
      repeat (8) begin
         @(negedge mclk);
         if (resp_valid === 1'b1 || reg_wr === 1'b1) n++;
      end
      cmd_valid = 1'b0;
      bgnd_mode = 1'b1;
      chk(32'(n), '0);
      send(bdm_pkg::read_data_reg_cmd, 4'h3, '0, '0);
      chk(resp_data, 32'h1111_2222);
      send(bdm_pkg::read_addr_reg_cmd, 4'h3, '0, '0);
      chk(resp_data, 32'h3333_4444);
      send(bdm_pkg::read_sys_reg_cmd, 4'h2, '0, '0);
      chk(resp_data, 32'h5555_6666);
   endtask
   // Read and dump at each size, then write and fill, slow answers
   task automatic t_mem;
      logic [31:0] a;
      lat = 4'h3;
      for (int i = 0; i < 3; i++) begin
         sz = bdm_pkg::mem_size_e'(i);
         send(bdm_pkg::mem_read_cmd, 4'h0, 32'h0000_0100, '0);
         chk({29'h0, lm.space}, {29'h0, ssel});
         a = 32'h0000_0100 + (32'h0000_0001 << i);
         send(bdm_pkg::dump_cmd, 4'h0, '0, '0);
         chk(lm.addr, a);
         chk({30'h0, lm.size}, {30'h0, sz});
         if (i == 2) chk(resp_data, a ^ 32'h5a5a_5a5a);
      end
      send(bdm_pkg::mem_write_cmd, 4'h0, 32'h0000_0300, 32'ha5a5_0001);
      chk({28'h0, lm.write, lm.space}, {29'h0000_0001, dsel});
      chk(lm.data, 32'ha5a5_0001);
      send(bdm_pkg::fill_cmd, 4'h0, '0, 32'ha5a5_0002);
      chk(lm.addr, 32'h0000_0304);
      chk(lm.data, 32'ha5a5_0002);
      lat = 4'h0;
   endtask
   // Resume, patch call, and a peripheral reset asked for twice
   task automatic t_ctl;
      send(bdm_pkg::resume_cmd, 4'h0, '0, '0);
      @(negedge mclk);
      chk(32'(ex_t - fl_t), 32'h0000_0001);
      pg = 1'b0;
      send(bdm_pkg::patch_call_cmd, 4'h0, '0, '0);
      chk(lm.addr, 32'h0000_7ffc);
      chk(lm.data, pc_value);
      @(negedge mclk);
      chk({31'h0, pg}, 32'h0000_0001);
      rst_cnt = 0;
      send(bdm_pkg::periph_reset_cmd, 4'h0, '0, '0);
      repeat (100) @(negedge mclk);
      send(bdm_pkg::periph_reset_cmd, 4'h0, '0, '0);
      repeat (500) @(negedge mclk);
      chk(32'(rst_cnt), 32'h0000_0200);
   endtask
   // Reset for four cycles, then the scenarios
   initial begin
      repeat (4) @(posedge mclk);
      @(negedge mclk);
      reset = 1'b0;
      t_regs();
      t_mem();
      t_ctl();
      results();
   end
   // Cuts a hung run short; the tests need under 1500 cycles
   initial begin
      #100000;
      failures++;
      results();
   end
endmodule

// *** bdm_cmd_properties.sv ***
// Checker for the debug command unit, watching its ports only.
// Assumes one clock, mclk, and reset asynchronous active high.
`timescale 1ns/1ps
module bdm_cmd_props (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset,
   // Command side
   input wire logic cmd_valid,
   input wire bdm_pkg::bdm_req_s cmd,
   input wire logic cmd_ready,
   input wire logic resp_valid,
   input wire logic [31:0] resp_data,
   input wire logic bgnd_mode,
   // Core side
   input wire logic reg_rd,
   input wire logic reg_wr,
   input wire logic reg_sys,
   input wire logic reg_ack,
   input wire logic [31:0] reg_rdata,
   input wire logic [31:0] pc_value,
   input wire logic [31:0] sp_value,
   input wire logic [2:0] source_space_select,
   input wire logic mem_valid,
   input wire bdm_pkg::mem_req_s mem_req,
   input wire logic pipe_flush,
   input wire logic exit_bgnd,
   input wire logic periph_reset
);
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   logic take;
   logic [9:0] run_q;
   // A command is taken at this edge
   assign take = cmd_valid && cmd_ready && bgnd_mode;
   // Cycles the peripheral reset has stood so far
   always_ff @(posedge mclk or posedge reset) begin
      if (reset)
         run_q <= '0;
      else
         run_q <= periph_reset ? run_q + 10'h001 : '0;
   end
   sequence resume_taken;
      take && cmd.op == bdm_pkg::resume_cmd;
   endsequence
   sequence flush_then_leave;
      pipe_flush ##1 exit_bgnd && resp_valid;
   endsequence
   a_dreg_read:
   assert property (reg_rd && !reg_sys && reg_ack |=> resp_valid
      && resp_data == $past(reg_rdata)) else $error("bad register read");
   a_sreg_read:
   assert property (reg_rd && reg_sys && reg_ack |=> resp_valid
      && resp_data == $past(reg_rdata)) else $error("bad system read");
   a_read_space:
   assert property (mem_valid && !mem_req.write |->
      mem_req.space == source_space_select) else $error("bad read space");
   a_resume_order:
   assert property (resume_taken |=> flush_then_leave)
      else $error("bad resume order");
   a_patch_push:
   assert property (take && cmd.op == bdm_pkg::patch_call_cmd |=> mem_valid
      && mem_req.write && mem_req.data == $past(pc_value)
      && mem_req.addr == $past(sp_value) - bdm_pkg::STACK_STEP)
      else $error("bad patch push");
   a_reset_len:
   assert property ((periph_reset |-> run_q < 10'h200)
      and ($fell(periph_reset) |-> run_q == 10'h200))
      else $error("bad reset length");
   a_nop_quiet:
   assert property (take && cmd.op == bdm_pkg::no_op_cmd |=> resp_valid
      && !mem_valid && !reg_wr && !pipe_flush) else $error("no-op acted");
   a_idle_ignore:
   assert property (cmd_ready && !bgnd_mode |=> !resp_valid && !mem_valid
      && !reg_rd && !reg_wr) else $error("command taken while running");
endmodule
bind bdm_cmd_unit bdm_cmd_props bdm_cmd_props_inst (.mclk, .reset,
   .cmd_valid, .cmd, .cmd_ready, .resp_valid, .resp_data, .bgnd_mode,
   .reg_rd, .reg_wr, .reg_sys, .reg_ack, .reg_rdata, .pc_value, .sp_value,
   .source_space_select, .mem_valid, .mem_req, .pipe_flush, .exit_bgnd,
   .periph_reset);

// *** bdm_cmd_unit.sv ***
// Background debug command unit: executes host debug commands against the
// core's register file, system registers and memory bus.
// Assumes commands arrive from a serial front end on mclk, one per strobe,
// and that the core answers register and memory requests with ack pulses.
`timescale 1ns/1ps

// Functional notes
// - Data/address register read returns value to host
// - Data/address register write loads host operand
// - System register read returns selected control register
// - System register write stores host operand
// - Memory read uses source space select
// - Memory write uses destination space select
// - Dump returns next operand after initial read
// - Fill writes next operand after initial write
// - Resume flushes, refills pipe, leaves background
// - Patch call pushes PC at SP - 4, jumps
// - Peripheral reset drives reset 512 cycles
// - No-op changes no state; the unit still loads reg_idx and reg_wdata from its operands
module bdm_cmd_unit (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset,
   // Command from serial front end
   input wire logic cmd_valid,
   input wire bdm_pkg::bdm_req_s cmd,
   output logic cmd_ready,
   output logic resp_valid,
   output logic [31:0] resp_data,
   // Core state and register file port
   input wire logic bgnd_mode,
   output logic reg_rd,
   output logic reg_wr,
   output logic reg_sys,
   output logic [3:0] reg_idx,
   output logic [31:0] reg_wdata,
   input wire logic reg_ack,
   input wire logic [31:0] reg_rdata,
   input wire logic [31:0] pc_value,
   input wire logic [31:0] sp_value,
   input wire logic [2:0] source_space_select,
   input wire logic [2:0] destination_space_select,
   // Memory bus request
   output logic mem_valid,
   output bdm_pkg::mem_req_s mem_req,
   input wire logic mem_ack,
   input wire logic [31:0] mem_rdata,
   // Execution control
   output logic pipe_flush,
   output logic exit_bgnd,
   output logic patch_go,
   output logic periph_reset
);

   typedef enum logic [2:0] {
      st_idle  = 3'b000,
      st_reg   = 3'b001,
      st_mem   = 3'b010,
      st_flush = 3'b011,
      st_push  = 3'b100
   } state_e;

   // Step the block address by operand size
   function automatic logic [31:0] step_addr(input logic [31:0] a,
                                             input bdm_pkg::mem_size_e s);
      logic [31:0] inc;
      inc = 32'h0000_0004;
      case (s)
         bdm_pkg::size_byte: inc = 32'h0000_0001;
         bdm_pkg::size_word: inc = 32'h0000_0002;
         default: inc = 32'h0000_0004;
      endcase
      return a + inc;
   endfunction

   state_e state_q, state_d;
   logic cmd_ready_q, cmd_ready_d;
   logic resp_valid_q, resp_valid_d;
   logic [31:0] resp_data_q, resp_data_d;
   logic reg_rd_q, reg_rd_d;
   logic reg_wr_q, reg_wr_d;
   logic reg_sys_q, reg_sys_d;
   logic [3:0] reg_idx_q, reg_idx_d;
   logic [31:0] reg_wdata_q, reg_wdata_d;
   logic mem_valid_q, mem_valid_d;
   bdm_pkg::mem_req_s mem_req_q, mem_req_d;
   logic [31:0] blk_addr_q, blk_addr_d;
   bdm_pkg::mem_size_e blk_size_q, blk_size_d;
   logic pipe_flush_q, pipe_flush_d;
   logic exit_bgnd_q, exit_bgnd_d;
   logic patch_go_q, patch_go_d;
   logic rst_act_q, rst_act_d;
   logic [9:0] rst_cnt_q, rst_cnt_d;
   logic take;

   assign take = cmd_valid && cmd_ready_q && bgnd_mode;

   // Command sequencer next state
   always_comb begin
      state_d = state_q;
      cmd_ready_d = cmd_ready_q;
      resp_valid_d = 1'b0;
      resp_data_d = resp_data_q;
      reg_rd_d = reg_rd_q;
      reg_wr_d = reg_wr_q;
      reg_sys_d = reg_sys_q;
      reg_idx_d = reg_idx_q;
      reg_wdata_d = reg_wdata_q;
      mem_valid_d = mem_valid_q;
      mem_req_d = mem_req_q;
      blk_addr_d = blk_addr_q;
      blk_size_d = blk_size_q;
      pipe_flush_d = 1'b0;
      exit_bgnd_d = 1'b0;
      patch_go_d = 1'b0;
      case (state_q)
         st_idle: begin
            cmd_ready_d = 1'b1;
            if (take) begin
               cmd_ready_d = 1'b0;
               reg_idx_d = cmd.reg_sel;
               reg_wdata_d = cmd.data;
               case (cmd.op)
                  bdm_pkg::read_data_reg_cmd: begin
                     reg_rd_d = 1'b1;
                     reg_sys_d = 1'b0;
                     reg_idx_d = {1'b0, cmd.reg_sel[2:0]};
                     state_d = st_reg;
                  end
                  bdm_pkg::read_addr_reg_cmd: begin
                     reg_rd_d = 1'b1;
                     reg_sys_d = 1'b0;
                     reg_idx_d = {1'b1, cmd.reg_sel[2:0]};
                     state_d = st_reg;
                  end
                  bdm_pkg::write_data_reg_cmd: begin
                     reg_wr_d = 1'b1;
                     reg_sys_d = 1'b0;
                     reg_idx_d = {1'b0, cmd.reg_sel[2:0]};
                     state_d = st_reg;
                  end
                  bdm_pkg::write_addr_reg_cmd: begin
                     reg_wr_d = 1'b1;
                     reg_sys_d = 1'b0;
                     reg_idx_d = {1'b1, cmd.reg_sel[2:0]};
                     state_d = st_reg;
                  end
                  bdm_pkg::read_sys_reg_cmd: begin
                     reg_rd_d = 1'b1;
                     reg_sys_d = 1'b1;
                     state_d = st_reg;
                  end
                  bdm_pkg::write_sys_reg_cmd: begin
                     reg_wr_d = 1'b1;
                     reg_sys_d = 1'b1;
                     state_d = st_reg;
                  end
                  bdm_pkg::mem_read_cmd: begin
                     mem_valid_d = 1'b1;
                     mem_req_d.write = 1'b0;
                     mem_req_d.space = source_space_select;
                     mem_req_d.size = cmd.size;
                     mem_req_d.addr = cmd.addr;
                     mem_req_d.data = bdm_pkg::DATA_RESET;
                     blk_addr_d = step_addr(cmd.addr, cmd.size);
                     blk_size_d = cmd.size;
                     state_d = st_mem;
                  end
                  bdm_pkg::mem_write_cmd: begin
                     mem_valid_d = 1'b1;
                     mem_req_d.write = 1'b1;
                     mem_req_d.space = destination_space_select;
                     mem_req_d.size = cmd.size;
                     mem_req_d.addr = cmd.addr;
                     mem_req_d.data = cmd.data;
                     blk_addr_d = step_addr(cmd.addr, cmd.size);
                     blk_size_d = cmd.size;
                     state_d = st_mem;
                  end
                  bdm_pkg::dump_cmd: begin
                     mem_valid_d = 1'b1;
                     mem_req_d.write = 1'b0;
                     mem_req_d.space = source_space_select;
                     mem_req_d.size = blk_size_q;
                     mem_req_d.addr = blk_addr_q;
                     mem_req_d.data = bdm_pkg::DATA_RESET;
                     blk_addr_d = step_addr(blk_addr_q, blk_size_q);
                     state_d = st_mem;
                  end
                  bdm_pkg::fill_cmd: begin
                     mem_valid_d = 1'b1;
                     mem_req_d.write = 1'b1;
                     mem_req_d.space = destination_space_select;
                     mem_req_d.size = blk_size_q;
                     mem_req_d.addr = blk_addr_q;
                     mem_req_d.data = cmd.data;
                     blk_addr_d = step_addr(blk_addr_q, blk_size_q);
                     state_d = st_mem;
                  end
                  bdm_pkg::resume_cmd: begin
                     pipe_flush_d = 1'b1;
                     state_d = st_flush;
                  end
                  bdm_pkg::patch_call_cmd: begin
                     mem_valid_d = 1'b1;
                     mem_req_d.write = 1'b1;
                     mem_req_d.space = destination_space_select;
                     mem_req_d.size = bdm_pkg::size_long;
                     mem_req_d.addr = sp_value
                        - bdm_pkg::STACK_STEP;
                     mem_req_d.data = pc_value;
                     state_d = st_push;
                  end
                  default: begin
                     // No-op and peripheral reset need no sequencing
                     cmd_ready_d = 1'b1;
                     resp_valid_d = 1'b1;
                  end
               endcase
            end
         end
         st_reg: begin
            if (reg_ack) begin
               reg_rd_d = 1'b0;
               reg_wr_d = 1'b0;
               resp_valid_d = 1'b1;
               if (reg_rd_q) begin
                  resp_data_d = reg_rdata;
               end
               cmd_ready_d = 1'b1;
               state_d = st_idle;
            end
         end
         st_mem: begin
            if (mem_ack) begin
               mem_valid_d = 1'b0;
               resp_valid_d = 1'b1;
               if (!mem_req_q.write) begin
                  resp_data_d = mem_rdata;
               end
               cmd_ready_d = 1'b1;
               state_d = st_idle;
            end
         end
         st_flush: begin
            exit_bgnd_d = 1'b1;
            resp_valid_d = 1'b1;
            cmd_ready_d = 1'b1;
            state_d = st_idle;
         end
         st_push: begin
            if (mem_ack) begin
               mem_valid_d = 1'b0;
               patch_go_d = 1'b1;
               exit_bgnd_d = 1'b1;
               resp_valid_d = 1'b1;
               cmd_ready_d = 1'b1;
               state_d = st_idle;
            end
         end
         default: begin
            state_d = st_idle;
         end
      endcase
   end

   // Peripheral reset counter next state
   always_comb begin
      rst_act_d = rst_act_q;
      rst_cnt_d = rst_cnt_q;
      if (take && cmd.op == bdm_pkg::periph_reset_cmd && state_q == st_idle
          && !rst_act_q) begin
         rst_act_d = 1'b1;
         rst_cnt_d = 10'h0000;
      end else if (rst_act_q) begin
         if (rst_cnt_q == bdm_pkg::PERIPH_RESET_LAST) begin
            rst_act_d = 1'b0;
         end else begin
            rst_cnt_d = rst_cnt_q + 10'h0001;
         end
      end
   end

   // State registers
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         state_q <= st_idle;
         cmd_ready_q <= 1'b0;
         resp_valid_q <= 1'b0;
         resp_data_q <= bdm_pkg::DATA_RESET;
         reg_rd_q <= 1'b0;
         reg_wr_q <= 1'b0;
         reg_sys_q <= 1'b0;
         reg_idx_q <= 4'h0;
         reg_wdata_q <= bdm_pkg::DATA_RESET;
         mem_valid_q <= 1'b0;
         mem_req_q <= '0;
         blk_addr_q <= bdm_pkg::ADDR_RESET;
         blk_size_q <= bdm_pkg::size_byte;
         pipe_flush_q <= 1'b0;
         exit_bgnd_q <= 1'b0;
         patch_go_q <= 1'b0;
         rst_act_q <= 1'b0;
         rst_cnt_q <= 10'h000;
      end else begin
         state_q <= state_d;
         cmd_ready_q <= cmd_ready_d;
         resp_valid_q <= resp_valid_d;
         resp_data_q <= resp_data_d;
         reg_rd_q <= reg_rd_d;
         reg_wr_q <= reg_wr_d;
         reg_sys_q <= reg_sys_d;
         reg_idx_q <= reg_idx_d;
         reg_wdata_q <= reg_wdata_d;
         mem_valid_q <= mem_valid_d;
         mem_req_q <= mem_req_d;
         blk_addr_q <= blk_addr_d;
         blk_size_q <= blk_size_d;
         pipe_flush_q <= pipe_flush_d;
         exit_bgnd_q <= exit_bgnd_d;
         patch_go_q <= patch_go_d;
         rst_act_q <= rst_act_d;
         rst_cnt_q <= rst_cnt_d;
      end
   end

   // Outputs straight from flip-flops
   assign cmd_ready = cmd_ready_q;
   assign resp_valid = resp_valid_q;
   assign resp_data = resp_data_q;
   assign reg_rd = reg_rd_q;
   assign reg_wr = reg_wr_q;
   assign reg_sys = reg_sys_q;
   assign reg_idx = reg_idx_q;
   assign reg_wdata = reg_wdata_q;
   assign mem_valid = mem_valid_q;
   assign mem_req = mem_req_q;
   assign pipe_flush = pipe_flush_q;
   assign exit_bgnd = exit_bgnd_q;
   assign patch_go = patch_go_q;
   assign periph_reset = rst_act_q;

endmodule

// *** bdm_pkg.sv ***
// Package for the background debug command unit: command codes, sizes,
// timing constants and the carrier structs shared with the top module.
// Assumes the surrounding core decodes the serial frame into a command word.
package bdm_pkg;

   // Command opcodes as delivered by the serial front end
   typedef enum logic [3:0] {
      read_data_reg_cmd  = 4'h0,
      read_addr_reg_cmd  = 4'h1,
      write_data_reg_cmd = 4'h2,
      write_addr_reg_cmd = 4'h3,
      read_sys_reg_cmd   = 4'h4,
      write_sys_reg_cmd  = 4'h5,
      mem_read_cmd       = 4'h6,
      mem_write_cmd      = 4'h7,
      dump_cmd           = 4'h8,
      fill_cmd           = 4'h9,
      resume_cmd         = 4'ha,
      patch_call_cmd     = 4'hb,
      periph_reset_cmd   = 4'hc,
      no_op_cmd          = 4'hd
   } bdm_cmd_e;

   // Operand size of memory accesses
   typedef enum logic [1:0] {
      size_byte = 2'b00,
      size_word = 2'b01,
      size_long = 2'b10
   } mem_size_e;

   // Command as handed over by the serial front end
   typedef struct packed {
      bdm_cmd_e  op;
      logic [3:0] reg_sel;
      mem_size_e size;
      logic [31:0] addr;
      logic [31:0] data;
   } bdm_req_s;

   // Memory access request toward the bus
   typedef struct packed {
      logic        write;
      logic [2:0]  space;
      mem_size_e   size;
      logic [31:0] addr;
      logic [31:0] data;
   } mem_req_s;

   // Peripheral reset pulse, in clock cycles
   localparam int unsigned PERIPH_RESET_CYCLES = 512;
   localparam logic [9:0] PERIPH_RESET_LAST = 10'h01ff;
   localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
   localparam logic [31:0] DATA_RESET = 32'h0000_0000;
   localparam logic [2:0] SPACE_RESET = 3'h0;
   localparam logic [31:0] STACK_STEP = 32'h0000_0004;

endpackage

// *** core_model.sv ***
// Core model: register file and memory answering the command unit.
// Assumes requests stand until acknowledged, ack after lat cycles.
`timescale 1ns/1ps
module core_model (
   // Clock, reset and answer delay
   input wire logic mclk,
   input wire logic reset,
   input wire logic [3:0] lat,
   // Register port
   input wire logic reg_rd,
   input wire logic reg_wr,
   input wire logic reg_sys,
   input wire logic [3:0] reg_idx,
   input wire logic [31:0] reg_wdata,
   output logic reg_ack,
   output logic [31:0] reg_rdata,
   // Memory port
   input wire logic mem_valid,
   input wire bdm_pkg::mem_req_s mem_req,
   output logic mem_ack,
   output logic [31:0] mem_rdata
);
   logic [31:0] regs [32];
   logic [3:0] rc_q, mc_q;
   logic [31:0] rv, mv;
   // Data is good only in the ack cycle, inverted otherwise
   assign rv = regs[{reg_sys, reg_idx}];
   assign mv = mem_req.addr ^ 32'h5a5a_5a5a;
   assign reg_rdata = reg_ack ? rv : ~rv;
   assign mem_rdata = mem_ack ? mv : ~mv;
   // One ack pulse per request after lat cycles
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         rc_q <= '0;
         mc_q <= '0;
         reg_ack <= 1'b0;
         mem_ack <= 1'b0;
      end else begin
         rc_q <= (reg_rd || reg_wr) && !reg_ack ? rc_q + 4'h1 : '0;
         reg_ack <= (reg_rd || reg_wr) && !reg_ack && rc_q == lat;
         mc_q <= mem_valid && !mem_ack ? mc_q + 4'h1 : '0;
         mem_ack <= mem_valid && !mem_ack && mc_q == lat;
      end
   end
   // Register writes land on their ack
   always_ff @(posedge mclk) begin
      if (reg_wr && reg_ack) regs[{reg_sys, reg_idx}] <= reg_wdata;
   end
endmodule
